// ---- shared/sspc_pkg.sv ----
// shared constants for the strap status and checker counter register bank
package sspc_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] SSPC_IDX_WRAP_CTRL = 8'h16;
	localparam logic [7:0] SSPC_IDX_STRAP_PRI = 8'h6E;
	localparam logic [7:0] SSPC_IDX_STRAP_SEC = 8'h6F;
	localparam logic [7:0] SSPC_IDX_BYTE_CNT = 8'h71;
	localparam logic [7:0] SSPC_IDX_ERR_OVF = 8'h72;
	localparam int SSPC_IDX_LSB = 2;
	localparam int SSPC_IDX_MSB = 9;

	// ----------------------------------------------------------------
	// bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] SSPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SSPC_RESP_SLVERR = 2'h2;
	localparam logic [31:0] SSPC_RD_ZERO = 32'h00000000;

	// ----------------------------------------------------------------
	// primary strap status field positions
	// ----------------------------------------------------------------
	localparam int SSPC_P_MIRROR = 15;
	localparam int SSPC_P_DOWNSHIFT = 14;
	localparam int SSPC_P_CLKOUT_OFF = 13;
	localparam int SSPC_P_RGMII_OFF = 12;
	localparam int SSPC_P_AMDIX_OFF = 10;
	localparam int SSPC_P_FORCED_PAIR = 9;
	localparam int SSPC_P_HALF_DUPLEX = 8;
	localparam int SSPC_P_ANEG_OFF = 7;
	localparam int SSPC_P_SPEED_LSB = 5;
	localparam int SSPC_P_SPEED_MSB = 6;
	localparam int SSPC_P_PHY_MSB_L = 4;
	localparam int SSPC_P_PHY_MSB_S = 3;

	// ----------------------------------------------------------------
	// secondary strap status and counter status and control field positions
	// ----------------------------------------------------------------
	localparam int SSPC_S_FAST_DROP = 10;
	localparam int SSPC_S_TX_LSB = 4;
	localparam int SSPC_S_TX_MSB = 6;
	localparam int SSPC_S_RX_MSB = 2;
	localparam int SSPC_C_PKT_OVF = 10;
	localparam int SSPC_C_BYTE_OVF = 9;
	localparam int SSPC_C_LOCK = 0;
	localparam int SSPC_C_CLEAR = 1;
	localparam int SSPC_C_WRAP = 0;

	// ----------------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------------
	localparam int SSPC_REG_W = 16;
	localparam int SSPC_BYTE_W = 16;
	localparam int SSPC_ERR_W = 8;
	localparam int SSPC_SPEED_W = 2;
	localparam int SSPC_PHY_W = 5;
	localparam int SSPC_SKEW_W = 3;
	localparam int SSPC_STRAP_W = 22;
	localparam logic [15:0] SSPC_BYTE_RST = 16'h0000;
	localparam logic [7:0] SSPC_ERR_RST = 8'h00;
	localparam logic SSPC_WRAP_RST = 1'b0;

endpackage

// ---- hdl/sspc_strap_latch.sv ----
// strap capture register, loaded only while reset is applied
module sspc_strap_latch
	import sspc_pkg::*;
#(
	parameter int WIDTH = SSPC_STRAP_W
) (
	input wire logic mclk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic [WIDTH-1:0] strap_i, // raw strap pin levels
	output logic [WIDTH-1:0] strap_o // captured strap levels
);

	initial begin
		if (WIDTH < 1) begin
			$error("sspc_strap_latch: WIDTH must be positive");
		end
	end

	// ----------------------------------------------------------------
	// capture
	// ----------------------------------------------------------------
	// the pins are followed on every clock edge while reset is high, so the value
	// held afterwards is the level seen at the last clock edge in reset
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			strap_o <= strap_i;
		end
	end

endmodule

// ---- hdl/sspc_top.sv ----
// strap status registers and checker counters behind an axi4-lite slave
module sspc_top
	import sspc_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter bit LARGE_PKG = 1'b1
) (
	input wire logic mclk_i, // 50 mhz clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // write address
	input wire logic s_axi_awvalid_i, // write address valid
	output logic s_axi_awready_o, // write address ready
	input wire logic [31:0] s_axi_wdata_i, // write data
	input wire logic [3:0] s_axi_wstrb_i, // write byte enables
	input wire logic s_axi_wvalid_i, // write data valid
	output logic s_axi_wready_o, // write data ready
	output logic [1:0] s_axi_bresp_o, // write response
	output logic s_axi_bvalid_o, // write response valid
	input wire logic s_axi_bready_i, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr_i, // read address
	input wire logic s_axi_arvalid_i, // read address valid
	output logic s_axi_arready_o, // read address ready
	output logic [31:0] s_axi_rdata_o, // read data
	output logic [1:0] s_axi_rresp_o, // read response
	output logic s_axi_rvalid_o, // read data valid
	input wire logic s_axi_rready_i, // read data ready
	input wire logic mirror_strap_i, // port mirroring strap
	input wire logic downshift_strap_i, // link downshift strap
	input wire logic clock_output_off_strap_i, // clock output off
	input wire logic reduced_gmii_off_strap_i, // mac interface off
	input wire logic auto_crossover_off_strap_i, // crossover off
	input wire logic forced_pairing_strap_i, // 1 crossed, 0 straight
	input wire logic half_duplex_strap_i, // half duplex strap
	input wire logic autoneg_off_strap_i, // auto-negotiation off
	input wire logic [1:0] speed_select_strap_field_i, // speed select
	input wire logic [4:0] phy_address_strap_i, // phy address
	input wire logic fast_drop_strap_i, // fast link drop strap
	input wire logic [2:0] tx_skew_strap_i, // transmit delay low bits
	input wire logic [2:0] rx_skew_strap_i, // receive delay low bits
	input wire logic chk_byte_i, // checker received a byte
	input wire logic chk_err_byte_i, // checker saw an error byte
	input wire logic chk_pkt_ovf_i, // packet counter overflowed
	output logic counter_wrap_select_o, // 0 saturate, 1 wrap
	output logic counter_lock_o, // lock pulse
	output logic counter_clear_o // clear pulse
);

	initial begin
		if (ADDR_W < SSPC_IDX_MSB + 2 || ADDR_W > 32) begin
			$error("sspc_top: ADDR_W must lie in 11..32");
		end
	end

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	logic [SSPC_STRAP_W-1:0] strap_raw;
	logic [SSPC_STRAP_W-1:0] strap_q;

	assign strap_raw = {mirror_strap_i, downshift_strap_i,
		clock_output_off_strap_i, reduced_gmii_off_strap_i,
		auto_crossover_off_strap_i, forced_pairing_strap_i,
		half_duplex_strap_i, autoneg_off_strap_i,
		speed_select_strap_field_i, phy_address_strap_i,
		fast_drop_strap_i, tx_skew_strap_i, rx_skew_strap_i};

	sspc_strap_latch #(
		.WIDTH(SSPC_STRAP_W)
	) u_latch (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.strap_i(strap_raw),
		.strap_o(strap_q)
	);

	logic mirror_q;
	logic downshift_q;
	logic clkout_off_q;
	logic rgmii_off_q;
	logic amdix_off_q;
	logic forced_pair_q;
	logic half_dup_q;
	logic aneg_off_q;
	logic [SSPC_SPEED_W-1:0] speed_q;
	logic [SSPC_PHY_W-1:0] phy_q;
	logic fast_drop_q;
	logic [SSPC_SKEW_W-1:0] tx_skew_q;
	logic [SSPC_SKEW_W-1:0] rx_skew_q;

	assign {mirror_q, downshift_q, clkout_off_q, rgmii_off_q, amdix_off_q,
		forced_pair_q, half_dup_q, aneg_off_q, speed_q, phy_q,
		fast_drop_q, tx_skew_q, rx_skew_q} = strap_q;

	// ----------------------------------------------------------------
	// strap status views
	// ----------------------------------------------------------------
	logic [SSPC_REG_W-1:0] strap_pri;
	logic [SSPC_REG_W-1:0] strap_sec;

	always_comb begin
		strap_pri = '0;
		strap_pri[SSPC_P_MIRROR] = mirror_q;
		strap_pri[SSPC_P_DOWNSHIFT] = downshift_q;
		strap_pri[SSPC_P_RGMII_OFF] = rgmii_off_q;
		strap_pri[SSPC_P_AMDIX_OFF] = amdix_off_q;
		strap_pri[SSPC_P_FORCED_PAIR] = forced_pair_q;
		strap_pri[SSPC_P_HALF_DUPLEX] = half_dup_q;
		strap_pri[SSPC_P_ANEG_OFF] = aneg_off_q;
		if (LARGE_PKG) begin
			strap_pri[SSPC_P_CLKOUT_OFF] = clkout_off_q;
			strap_pri[SSPC_P_SPEED_MSB:SSPC_P_SPEED_LSB] = speed_q;
			strap_pri[SSPC_P_PHY_MSB_L:0] = phy_q;
		end else begin
			// the small variant has one speed pin and four address pins
			strap_pri[SSPC_P_SPEED_LSB] = speed_q[0];
			strap_pri[SSPC_P_PHY_MSB_S:0] = phy_q[SSPC_P_PHY_MSB_S:0];
		end
	end

	always_comb begin
		strap_sec = '0;
		strap_sec[SSPC_S_FAST_DROP] = fast_drop_q;
		if (!LARGE_PKG) begin
			strap_sec[SSPC_S_TX_MSB:SSPC_S_TX_LSB] = tx_skew_q;
			strap_sec[SSPC_S_RX_MSB:0] = rx_skew_q;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [7:0] wr_idx;
	logic wr_top_zero;
	logic wr_hit_ctrl;
	logic wr_hit_ro;
	logic wr_hit_cnt;

	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
	assign do_write = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_idx = aw_addr[SSPC_IDX_MSB:SSPC_IDX_LSB];
	assign wr_top_zero = (aw_addr[ADDR_W-1:SSPC_IDX_MSB+1] == '0);
	assign wr_hit_ctrl = wr_top_zero && (wr_idx == SSPC_IDX_WRAP_CTRL);
	assign wr_hit_cnt = wr_top_zero && (wr_idx == SSPC_IDX_ERR_OVF);
	assign wr_hit_ro = wr_top_zero && (wr_idx == SSPC_IDX_STRAP_PRI
		|| wr_idx == SSPC_IDX_STRAP_SEC || wr_idx == SSPC_IDX_BYTE_CNT);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i;
			w_strb <= s_axi_wstrb_i;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// read-only registers accept a write silently; unmapped ones refuse
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= SSPC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= (wr_hit_ctrl || wr_hit_ro || wr_hit_cnt) ?
				SSPC_RESP_OKAY : SSPC_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			counter_wrap_select_o <= SSPC_WRAP_RST;
		end else if (do_write && wr_hit_ctrl && w_strb[0]) begin
			counter_wrap_select_o <= w_data[SSPC_C_WRAP];
		end
	end

	// ----------------------------------------------------------------
	// lock and clear triggers
	// ----------------------------------------------------------------
	logic cnt_write;

	assign cnt_write = do_write && wr_hit_cnt && w_strb[0];
	assign counter_lock_o = cnt_write
		&& (w_data[SSPC_C_LOCK] || w_data[SSPC_C_CLEAR]);
	assign counter_clear_o = cnt_write && w_data[SSPC_C_CLEAR];

	// ----------------------------------------------------------------
	// checker counters
	// ----------------------------------------------------------------
	logic [SSPC_BYTE_W-1:0] byte_cnt;
	logic [SSPC_ERR_W-1:0] err_cnt;
	logic [SSPC_BYTE_W-1:0] byte_snap;
	logic [SSPC_ERR_W-1:0] err_snap;
	logic byte_ovf;
	logic pkt_ovf;
	logic byte_at_max;
	logic err_at_max;

	assign byte_at_max = &byte_cnt;
	assign err_at_max = &err_cnt;

	// a byte arriving with the clear is counted as the first of the run
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			byte_cnt <= SSPC_BYTE_RST;
		end else if (counter_clear_o) begin
			byte_cnt <= SSPC_BYTE_W'(chk_byte_i);
		end else if (chk_byte_i && (!byte_at_max || counter_wrap_select_o)) begin
			byte_cnt <= byte_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			err_cnt <= SSPC_ERR_RST;
		end else if (counter_clear_o) begin
			err_cnt <= SSPC_ERR_W'(chk_err_byte_i);
		end else if (chk_err_byte_i && (!err_at_max || counter_wrap_select_o)) begin
			err_cnt <= err_cnt + 1'b1;
		end
	end

	// readers see the snapshot, so a multi-read sequence stays coherent
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			byte_snap <= SSPC_BYTE_RST;
			err_snap <= SSPC_ERR_RST;
		end else if (counter_lock_o) begin
			byte_snap <= byte_cnt;
			err_snap <= err_cnt;
		end
	end

	// overflow events win over a clear in the same cycle
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			byte_ovf <= 1'b0;
		end else if (chk_byte_i && byte_at_max) begin
			byte_ovf <= 1'b1;
		end else if (counter_clear_o) begin
			byte_ovf <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pkt_ovf <= 1'b0;
		end else if (chk_pkt_ovf_i) begin
			pkt_ovf <= 1'b1;
		end else if (counter_clear_o) begin
			pkt_ovf <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	logic [7:0] rd_idx;
	logic rd_top_zero;
	logic [SSPC_REG_W-1:0] cnt_status;
	logic [SSPC_REG_W-1:0] rd_val;
	logic rd_hit;
	logic rd_take;

	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign rd_take = s_axi_arvalid_i && s_axi_arready_o;
	assign rd_idx = s_axi_araddr_i[SSPC_IDX_MSB:SSPC_IDX_LSB];
	assign rd_top_zero = (s_axi_araddr_i[ADDR_W-1:SSPC_IDX_MSB+1] == '0);

	always_comb begin
		cnt_status = '0;
		cnt_status[SSPC_C_PKT_OVF] = pkt_ovf;
		cnt_status[SSPC_C_BYTE_OVF] = byte_ovf;
		cnt_status[SSPC_ERR_W-1:0] = err_snap;
	end

	always_comb begin
		rd_val = '0;
		rd_hit = rd_top_zero;
		case (rd_idx)
			SSPC_IDX_WRAP_CTRL: rd_val[SSPC_C_WRAP] = counter_wrap_select_o;
			SSPC_IDX_STRAP_PRI: rd_val = strap_pri;
			SSPC_IDX_STRAP_SEC: rd_val = strap_sec;
			SSPC_IDX_BYTE_CNT: rd_val = byte_snap;
			SSPC_IDX_ERR_OVF: rd_val = cnt_status;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= SSPC_RD_ZERO;
			s_axi_rresp_o <= SSPC_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_hit ? {16'h0000, rd_val} : SSPC_RD_ZERO;
			s_axi_rresp_o <= rd_hit ? SSPC_RESP_OKAY : SSPC_RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_read_pri;
		rd_take && rd_top_zero && rd_idx == SSPC_IDX_STRAP_PRI;
	endsequence

	sequence s_read_sec;
		rd_take && rd_top_zero && rd_idx == SSPC_IDX_STRAP_SEC;
	endsequence

	sequence s_lock_clear;
		counter_clear_o && !chk_byte_i && !chk_err_byte_i;
	endsequence

	a_strap_held: assert property (
		!$past(rst_i) |-> $stable(strap_q))
		else $error("strap capture changed outside reset");

	a_mirror_read: assert property (
		s_read_pri |=> s_axi_rdata_o[SSPC_P_MIRROR] == mirror_q
			&& s_axi_rdata_o[SSPC_P_DOWNSHIFT] == downshift_q)
		else $error("mirror or downshift strap misreported");

	a_pri_reserved: assert property (
		s_read_pri |=> s_axi_rdata_o[11] == 1'b0
			&& s_axi_rdata_o[SSPC_P_AMDIX_OFF] == amdix_off_q)
		else $error("crossover strap or reserved bit wrong");

	a_phy_addr: assert property (
		s_read_pri |=> LARGE_PKG ? s_axi_rdata_o[4:0] == phy_q
			: s_axi_rdata_o[6] == 1'b0 && s_axi_rdata_o[4] == 1'b0)
		else $error("phy address field misreported");

	a_sec_reserved: assert property (
		s_read_sec |=> s_axi_rdata_o[15:11] == 5'h00
			&& s_axi_rdata_o[3] == 1'b0
			&& s_axi_rdata_o[SSPC_S_FAST_DROP] == fast_drop_q)
		else $error("secondary strap register wrong");

	a_byte_saturate: assert property (
		!counter_wrap_select_o && byte_at_max && !counter_clear_o
			|=> byte_at_max)
		else $error("byte total left its maximum in saturate mode");

	a_err_saturate: assert property (
		!counter_wrap_select_o && err_at_max && !counter_clear_o
			|=> err_at_max)
		else $error("error total left its maximum in saturate mode");

	a_lock_snapshot: assert property (
		counter_lock_o |=> byte_snap == $past(byte_cnt)
			&& err_snap == $past(err_cnt))
		else $error("snapshot does not match counters");

	a_snap_frozen: assert property (
		!counter_lock_o |=> $stable(byte_snap) && $stable(err_snap))
		else $error("snapshot moved without a lock");

	a_clear_zero: assert property (
		s_lock_clear |=> byte_cnt == SSPC_BYTE_RST && err_cnt == SSPC_ERR_RST
			&& !byte_ovf ##1 byte_cnt <= 16'h0001)
		else $error("clear did not restart the counters");

	a_byte_ovf_sticky: assert property (
		byte_ovf && !counter_clear_o |=> byte_ovf)
		else $error("byte overflow flag dropped without clear");

	a_pkt_ovf_set: assert property (
		chk_pkt_ovf_i |=> pkt_ovf)
		else $error("packet overflow flag not set");

	a_write_answer: assert property (
		do_write |=> s_axi_bvalid_o && !aw_held && !w_held)
		else $error("write response missing after both channels");

endmodule

// ---- tb/sspc_top_tb.sv ----
// self-checking bench for the strap status and checker counter bank
module sspc_top_tb
	import sspc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [21:0] strap_v = '0;
	logic cb = 1'b0, ce = 1'b0, cp = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rdata_s;
	logic wrap_sel, lock_p, clr_p;
	int failures = 0;
	int checks_done = 0;
	int lock_cnt = 0;
	int clr_cnt = 0;

	// the small variant sees identical traffic; only its read data is used
	sspc_top u_sspc_top (.mclk_i(mclk), .rst_i(rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .mirror_strap_i(strap_v[21]),
		.downshift_strap_i(strap_v[20]),
		.clock_output_off_strap_i(strap_v[19]),
		.reduced_gmii_off_strap_i(strap_v[18]),
		.auto_crossover_off_strap_i(strap_v[17]),
		.forced_pairing_strap_i(strap_v[16]),
		.half_duplex_strap_i(strap_v[15]), .autoneg_off_strap_i(strap_v[14]),
		.speed_select_strap_field_i(strap_v[13:12]),
		.phy_address_strap_i(strap_v[11:7]), .fast_drop_strap_i(strap_v[6]),
		.tx_skew_strap_i(strap_v[5:3]), .rx_skew_strap_i(strap_v[2:0]),
		.chk_byte_i(cb), .chk_err_byte_i(ce), .chk_pkt_ovf_i(cp),
		.counter_wrap_select_o(wrap_sel), .counter_lock_o(lock_p),
		.counter_clear_o(clr_p));

	sspc_top #(.LARGE_PKG(1'b0)) u_sspc_top_small (.mclk_i(mclk), .rst_i(rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(), .s_axi_bresp_o(),
		.s_axi_bvalid_o(), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(),
		.s_axi_rdata_o(rdata_s), .s_axi_rresp_o(), .s_axi_rvalid_o(),
		.s_axi_rready_i(rready), .mirror_strap_i(strap_v[21]),
		.downshift_strap_i(strap_v[20]),
		.clock_output_off_strap_i(strap_v[19]),
		.reduced_gmii_off_strap_i(strap_v[18]),
		.auto_crossover_off_strap_i(strap_v[17]),
		.forced_pairing_strap_i(strap_v[16]),
		.half_duplex_strap_i(strap_v[15]), .autoneg_off_strap_i(strap_v[14]),
		.speed_select_strap_field_i(strap_v[13:12]),
		.phy_address_strap_i(strap_v[11:7]), .fast_drop_strap_i(strap_v[6]),
		.tx_skew_strap_i(strap_v[5:3]), .rx_skew_strap_i(strap_v[2:0]),
		.chk_byte_i(cb), .chk_err_byte_i(ce), .chk_pkt_ovf_i(cp),
		.counter_wrap_select_o(), .counter_lock_o(), .counter_clear_o());

	initial begin
		forever #10 mclk = ~mclk;
	end

	// pulses are one cycle wide, so each edge counts at most one
	always @(posedge mclk) begin
		if (!rst && lock_p === 1'b1) lock_cnt++;
		if (!rst && clr_p === 1'b1) clr_cnt++;
	end

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic hang();
		failures++;
		$display("BAD %0t bus answer missing", $time);
		stop_test();
	endtask

	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	function automatic logic [31:0] exp_pri(input logic [21:0] s, input bit lg);
		if (lg) return {16'h0000, s[21:18], 1'b0, s[17:14], s[13:7]};
		return {16'h0000, s[21:20], 1'b0, s[18], 1'b0, s[17:14], 1'b0,
			s[12], 1'b0, s[10:7]};
	endfunction

	function automatic logic [31:0] exp_sec(input logic [21:0] s, input bit lg);
		if (lg) return {21'h000000, s[6], 10'h000};
		return {21'h000000, s[6], 3'b000, s[5:3], 1'b0, s[2:0]};
	endfunction

	// aw and w offered together; bready held until bvalid is seen
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (n == 50) hang();
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [31:0] ds, output logic [1:0] r);
		int n;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (n == 50) hang();
		d = rdata;
		ds = rdata_s;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic pulses(input int n, input logic b, input logic e,
		input logic p);
		repeat (n) begin
			@(posedge mclk);
			cb <= b;
			ce <= e;
			cp <= p;
		end
		@(posedge mclk);
		cb <= 1'b0;
		ce <= 1'b0;
		cp <= 1'b0;
	endtask

	task automatic do_reset(input logic [21:0] s);
		@(posedge mclk);
		rst <= 1'b1;
		strap_v <= s;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_straps(input logic [21:0] s);
		logic [31:0] d, ds;
		logic [1:0] r;
		rd(ba(SSPC_IDX_STRAP_PRI), d, ds, r);
		chk({30'h0, r}, {30'h0, SSPC_RESP_OKAY}, "strap read resp");
		chk(d, exp_pri(s, 1'b1), "primary large");
		chk(ds, exp_pri(s, 1'b0), "primary small");
		rd(ba(SSPC_IDX_STRAP_SEC), d, ds, r);
		chk(d, exp_sec(s, 1'b1), "secondary large");
		chk(ds, exp_sec(s, 1'b0), "secondary small");
		// pins move after reset; the captured copy must not
		strap_v <= ~s;
		rd(ba(SSPC_IDX_STRAP_PRI), d, ds, r);
		chk(d, exp_pri(s, 1'b1), "primary held");
		rd(ba(SSPC_IDX_STRAP_SEC), d, ds, r);
		chk(ds, exp_sec(s, 1'b0), "secondary held");
		$display("strap test done");
	endtask

	task automatic t_bus(input logic [21:0] s);
		logic [31:0] d, ds;
		logic [1:0] r;
		rd(ba(SSPC_IDX_WRAP_CTRL), d, ds, r);
		chk(d, 32'h00000000, "wrap select reset");
		wr(ba(SSPC_IDX_WRAP_CTRL), 32'h00000001, r);
		chk({31'h0, wrap_sel}, 32'h00000001, "wrap select out");
		rd(ba(SSPC_IDX_WRAP_CTRL), d, ds, r);
		chk(d, 32'h00000001, "wrap select readback");
		wr(ba(SSPC_IDX_WRAP_CTRL), 32'h00000000, r);
		rd(12'h7FC, d, ds, r);
		chk({30'h0, r}, {30'h0, SSPC_RESP_SLVERR}, "unmapped resp");
		chk(d, SSPC_RD_ZERO, "unmapped data");
		wr(12'h7FC, 32'h00000003, r);
		chk({30'h0, r}, {30'h0, SSPC_RESP_SLVERR}, "unmapped write resp");
		rd(12'h800 | ba(SSPC_IDX_STRAP_PRI), d, ds, r);
		chk({30'h0, r}, {30'h0, SSPC_RESP_SLVERR}, "high bits resp");
		wr(ba(SSPC_IDX_STRAP_PRI), 32'h0000FFFF, r);
		chk({30'h0, r}, {30'h0, SSPC_RESP_OKAY}, "ro write resp");
		rd(ba(SSPC_IDX_STRAP_PRI), d, ds, r);
		chk(d, exp_pri(s, 1'b1), "ro write ignored");
		$display("bus test done");
	endtask

	task automatic t_count();
		logic [31:0] d, ds;
		logic [1:0] r;
		int l0, c0;
		rd(ba(SSPC_IDX_BYTE_CNT), d, ds, r);
		chk(d, 32'h00000000, "byte total reset");
		rd(ba(SSPC_IDX_ERR_OVF), d, ds, r);
		chk(d, 32'h00000000, "status reset");
		pulses(3, 1'b1, 1'b1, 1'b0);
		pulses(2, 1'b1, 1'b0, 1'b0);
		l0 = lock_cnt;
		c0 = clr_cnt;
		wr(ba(SSPC_IDX_ERR_OVF), 32'h00000001, r);
		chk(lock_cnt - l0, 32'h00000001, "lock pulse");
		chk(clr_cnt - c0, 32'h00000000, "no clear pulse");
		rd(ba(SSPC_IDX_BYTE_CNT), d, ds, r);
		chk(d, 32'h00000005, "byte snapshot");
		rd(ba(SSPC_IDX_ERR_OVF), d, ds, r);
		chk(d, 32'h00000003, "error snapshot");
		// counting on after the lock must not disturb the snapshot
		pulses(4, 1'b1, 1'b1, 1'b0);
		rd(ba(SSPC_IDX_BYTE_CNT), d, ds, r);
		chk(d, 32'h00000005, "byte frozen");
		rd(ba(SSPC_IDX_ERR_OVF), d, ds, r);
		chk(d, 32'h00000003, "error frozen");
		$display("count test done");
	endtask

	task automatic t_sat();
		logic [31:0] d, ds;
		logic [1:0] r;
		int l0, c0;
		pulses(65540, 1'b1, 1'b1, 1'b0);
		wr(ba(SSPC_IDX_ERR_OVF), 32'h00000001, r);
		rd(ba(SSPC_IDX_BYTE_CNT), d, ds, r);
		chk(d, 32'h0000FFFF, "byte saturates");
		rd(ba(SSPC_IDX_ERR_OVF), d, ds, r);
		chk(d, 32'h000002FF, "byte ovf and error sat");
		pulses(1, 1'b0, 1'b0, 1'b1);
		rd(ba(SSPC_IDX_ERR_OVF), d, ds, r);
		chk(d, 32'h000006FF, "packet ovf");
		l0 = lock_cnt;
		c0 = clr_cnt;
		wr(ba(SSPC_IDX_ERR_OVF), 32'h00000002, r);
		chk(lock_cnt - l0, 32'h00000001, "clear locks");
		chk(clr_cnt - c0, 32'h00000001, "clear pulse");
		rd(ba(SSPC_IDX_ERR_OVF), d, ds, r);
		chk(d, 32'h000000FF, "flags cleared");
		wr(ba(SSPC_IDX_ERR_OVF), 32'h00000001, r);
		rd(ba(SSPC_IDX_BYTE_CNT), d, ds, r);
		chk(d, 32'h00000000, "byte after clear");
		rd(ba(SSPC_IDX_ERR_OVF), d, ds, r);
		chk(d, 32'h00000000, "error after clear");
		$display("saturation test done");
	endtask

	// wrap mode: the error total rolls over, the byte total counts on to 258
	task automatic t_wrap();
		logic [31:0] d, ds;
		logic [1:0] r;
		wr(ba(SSPC_IDX_WRAP_CTRL), 32'h00000001, r);
		pulses(258, 1'b1, 1'b1, 1'b0);
		wr(ba(SSPC_IDX_ERR_OVF), 32'h00000001, r);
		rd(ba(SSPC_IDX_BYTE_CNT), d, ds, r);
		chk(d, 32'h00000102, "byte total in wrap mode");
		rd(ba(SSPC_IDX_ERR_OVF), d, ds, r);
		chk(d, 32'h00000002, "error total wraps");
		$display("wrap test done");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset(22'h2B5A93);
		t_straps(22'h2B5A93);
		t_bus(22'h2B5A93);
		t_count();
		t_sat();
		t_wrap();
		do_reset(~22'h2B5A93);
		t_straps(~22'h2B5A93);
		stop_test();
	end
endmodule
